// ==== rtl/clk_mode_pkg.sv ====
package clk_mode_pkg;

////////////////////////////////////////////////////////////////////////////
// Oscillator mode encoding on osc_mode_select_bits
typedef enum logic [3:0] {
	STD_CRYSTAL_MODE = 4'h0,
	STD_CRYSTAL_PLL_MODE = 4'h1,
	FAST_CRYSTAL_MODE = 4'h2,
	FAST_CRYSTAL_PLL_MODE = 4'h3,
	EXT_CLOCK_CLKOUT_MODE = 4'h4,
	EXT_CLOCK_IO_MODE = 4'h5,
	EXT_CLOCK_PLL_CLKOUT_MODE = 4'h6,
	EXT_CLOCK_PLL_IO_MODE = 4'h7,
	INTERNAL_CORE_FAST_CRYSTAL_USB = 4'h8,
	INTERNAL_CORE_STD_CRYSTAL_USB = 4'h9,
	INTERNAL_CORE_EXTCLK_USB_IO = 4'ha,
	INTERNAL_CORE_EXTCLK_USB_CLKOUT = 4'hb
} osc_mode_type;

// Run-time core clock source
typedef enum logic [1:0] {
	SRC_PRIMARY = 2'h0,
	SRC_SECONDARY = 2'h1,
	SRC_INTERNAL = 2'h2
} core_src_type;

// Start-up state machine, Gray coded
typedef enum logic [1:0] {
	ST_START = 2'h0,
	ST_WAIT = 2'h1,
	ST_RUN = 2'h3,
	ST_SLEEP = 2'h2
} startup_state_type;

////////////////////////////////////////////////////////////////////////////
// Register byte addresses
localparam logic [7:0] CLOCK_CONFIG_LOW_ADDR = 8'h00;
localparam logic [7:0] CLOCK_CONFIG_HIGH_ADDR = 8'h04;
localparam logic [7:0] ACTIVE_CLOCK_CONTROL_ADDR = 8'h08;
localparam logic [7:0] CLOCK_STATUS_ADDR = 8'h0c;
localparam logic [7:0] CONFIG_KEY_ADDR = 8'h10;
localparam logic [7:0] PORT_A_BIT6_ADDR = 8'h14;

// Values and reset values
localparam logic [7:0] CONFIG_KEY_VALUE = 8'ha5;
localparam logic [3:0] MODE_RESET = 4'h2;
localparam logic [1:0] POSTSCALE_RESET = 2'h0;
localparam logic [1:0] CLKOUT_RATIO = 2'h1;
localparam logic [1:0] USB_LOW_SPEED_RATIO = 2'h3;
localparam int STARTUP_CYCLES = 1024;

////////////////////////////////////////////////////////////////////////////
// Carriers
typedef struct packed {
	logic wake;
	logic osc_in;
	logic osc_out;
	logic pll;
	logic secondary;
	logic internal;
} pins_type;

typedef struct packed {
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
} ahb_resp_type;

typedef struct packed {
	logic [1:0] cnt;
	logic tick;
} div_state_type;

endpackage

// ==== rtl/tick_divider.sv ====
`timescale 1ns/1ns
module tick_divider (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic tick_in,
	input wire logic [1:0] ratio_in,
	output logic tick_out
);

clk_mode_pkg::div_state_type s_reg;
clk_mode_pkg::div_state_type s_next;

// Divide input ticks by ratio_in plus one
always_comb begin
	s_next = s_reg;
	s_next.tick = 1'b0;
	if (tick_in) begin
		if (s_reg.cnt >= ratio_in) begin
			s_next.cnt = 2'h0;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 2'h1;
		end
	end
end

always_ff @(posedge core_clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		s_reg <= '0;
	end else begin
		s_reg <= s_next;
	end
end

assign tick_out = s_reg.tick;

endmodule

// ==== rtl/usb_mcu_clock_mode_select.sv ====
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module usb_mcu_clock_mode_select #(
	parameter int STARTUP_CYCLES = clk_mode_pkg::STARTUP_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire clk_mode_pkg::pins_type pins_in,
	output clk_mode_pkg::ahb_resp_type ahb_out,
	output logic core_tick_out,
	output logic usb_tick_out,
	output logic osc_out_pin_out,
	output logic osc_out_pin_oe_n_out,
	output logic core_running_out
);

////////////////////////////////////////////////////////////////////////////
// State
typedef struct packed {
	clk_mode_pkg::pins_type sync1;
	clk_mode_pkg::pins_type sync2;
	logic osc_prev;
	logic [3:0] mode;
	logic [1:0] postscale;
	logic usb_full;
	logic usb_en;
	logic [1:0] src;
	logic sleep_req;
	logic armed;
	logic pa6_out;
	logic pa6_drive;
	clk_mode_pkg::startup_state_type fsm;
	logic [15:0] cnt;
	logic wr_pend;
	logic [2:0] wr_idx;
	logic [31:0] rdata;
	logic ready;
	logic clkout_lvl;
	logic core_tick;
	logic usb_tick;
	logic pin_out;
	logic pin_oe_n;
} state_type;

state_type s_reg;
state_type s_next;
logic prim_tick;
logic post_in;
logic post_tick;
logic half_tick;
logic ls_tick;
logic [1:0] eff_src;

////////////////////////////////////////////////////////////////////////////
// Mode decoding
function automatic logic is_ext(input logic [3:0] m);
	is_ext = m inside {clk_mode_pkg::EXT_CLOCK_CLKOUT_MODE,
		clk_mode_pkg::EXT_CLOCK_IO_MODE,
		clk_mode_pkg::EXT_CLOCK_PLL_CLKOUT_MODE,
		clk_mode_pkg::EXT_CLOCK_PLL_IO_MODE};
endfunction

function automatic logic is_pll(input logic [3:0] m);
	is_pll = m inside {clk_mode_pkg::STD_CRYSTAL_PLL_MODE,
		clk_mode_pkg::FAST_CRYSTAL_PLL_MODE,
		clk_mode_pkg::EXT_CLOCK_PLL_CLKOUT_MODE,
		clk_mode_pkg::EXT_CLOCK_PLL_IO_MODE};
endfunction

function automatic logic is_io(input logic [3:0] m);
	is_io = m inside {clk_mode_pkg::EXT_CLOCK_IO_MODE,
		clk_mode_pkg::EXT_CLOCK_PLL_IO_MODE,
		clk_mode_pkg::INTERNAL_CORE_EXTCLK_USB_IO};
endfunction

function automatic logic is_clkout(input logic [3:0] m);
	is_clkout = m inside {clk_mode_pkg::EXT_CLOCK_CLKOUT_MODE,
		clk_mode_pkg::EXT_CLOCK_PLL_CLKOUT_MODE,
		clk_mode_pkg::INTERNAL_CORE_EXTCLK_USB_CLKOUT};
endfunction

function automatic logic is_int(input logic [3:0] m);
	is_int = (m >= clk_mode_pkg::INTERNAL_CORE_FAST_CRYSTAL_USB) &&
		(m <= clk_mode_pkg::INTERNAL_CORE_EXTCLK_USB_CLKOUT);
endfunction

////////////////////////////////////////////////////////////////////////////
// Clock ticks and dividers
assign prim_tick = s_reg.sync2.osc_in & ~s_reg.osc_prev;
assign post_in = is_pll(s_reg.mode) ? s_reg.sync2.pll : prim_tick;
assign eff_src = (is_int(s_reg.mode) &&
	s_reg.src == clk_mode_pkg::SRC_PRIMARY) ?
	clk_mode_pkg::SRC_INTERNAL : s_reg.src;

tick_divider u_postscale (
	.core_clk_in(core_clk_in),
	.nrst_in(nrst_in),
	.tick_in(post_in),
	.ratio_in(s_reg.postscale),
	.tick_out(post_tick)
);

tick_divider u_clkout (
	.core_clk_in(core_clk_in),
	.nrst_in(nrst_in),
	.tick_in(prim_tick),
	.ratio_in(clk_mode_pkg::CLKOUT_RATIO),
	.tick_out(half_tick)
);

tick_divider u_usb_low (
	.core_clk_in(core_clk_in),
	.nrst_in(nrst_in),
	.tick_in(prim_tick),
	.ratio_in(clk_mode_pkg::USB_LOW_SPEED_RATIO),
	.tick_out(ls_tick)
);

////////////////////////////////////////////////////////////////////////////
// Next state
always_comb begin
	s_next = s_reg;
	s_next.sync1 = pins_in;
	s_next.sync2 = s_reg.sync1;
	s_next.osc_prev = s_reg.sync2.osc_in;
	s_next.ready = 1'b1;
	s_next.wr_pend = 1'b0;
	// Bus address phase
	if (hsel_in && hready_in && htrans_in[1]) begin
		s_next.wr_pend = hwrite_in && haddr_in[31:5] == 27'h0;
		s_next.wr_idx = haddr_in[4:2];
		s_next.rdata = 32'h0;
		if (!hwrite_in && haddr_in[31:5] == 27'h0) begin
			case ({haddr_in[4:2], 2'h0})
			clk_mode_pkg::CLOCK_CONFIG_LOW_ADDR[4:0]: begin
				s_next.rdata[2:0] = {s_reg.usb_full, s_reg.postscale};
			end
			clk_mode_pkg::CLOCK_CONFIG_HIGH_ADDR[4:0]: begin
				s_next.rdata[3:0] = s_reg.mode;
			end
			clk_mode_pkg::ACTIVE_CLOCK_CONTROL_ADDR[4:0]: begin
				s_next.rdata[3:0] = {s_reg.usb_en, s_reg.sleep_req,
					s_reg.src};
			end
			clk_mode_pkg::CLOCK_STATUS_ADDR[4:0]: begin
				s_next.rdata[5:0] = {eff_src, is_clkout(s_reg.mode),
					is_pll(s_reg.mode),
					s_reg.fsm == clk_mode_pkg::ST_SLEEP,
					s_reg.fsm == clk_mode_pkg::ST_RUN};
			end
			clk_mode_pkg::CONFIG_KEY_ADDR[4:0]: begin
				s_next.rdata[0] = s_reg.armed;
			end
			clk_mode_pkg::PORT_A_BIT6_ADDR[4:0]: begin
				s_next.rdata[2:0] = {s_reg.sync2.osc_out,
					s_reg.pa6_drive, s_reg.pa6_out};
			end
			default: begin
				s_next.rdata = 32'h0;
			end
			endcase
		end
	end
	// Bus data phase write
	if (s_reg.wr_pend) begin
		case ({s_reg.wr_idx, 2'h0})
		clk_mode_pkg::CLOCK_CONFIG_LOW_ADDR[4:0]: begin
			if (s_reg.armed) begin
				s_next.postscale = hwdata_in[1:0];
				s_next.usb_full = hwdata_in[2];
				s_next.armed = 1'b0;
			end
		end
		clk_mode_pkg::CLOCK_CONFIG_HIGH_ADDR[4:0]: begin
			if (s_reg.armed && hwdata_in[3:0] <=
				clk_mode_pkg::INTERNAL_CORE_EXTCLK_USB_CLKOUT) begin
				s_next.mode = hwdata_in[3:0];
				s_next.armed = 1'b0;
			end
		end
		clk_mode_pkg::ACTIVE_CLOCK_CONTROL_ADDR[4:0]: begin
			if (hwdata_in[1:0] != 2'h3) begin
				s_next.src = hwdata_in[1:0];
			end
			s_next.sleep_req = hwdata_in[2];
			s_next.usb_en = hwdata_in[3];
		end
		clk_mode_pkg::CONFIG_KEY_ADDR[4:0]: begin
			s_next.armed = (hwdata_in[7:0] ==
				clk_mode_pkg::CONFIG_KEY_VALUE);
		end
		clk_mode_pkg::PORT_A_BIT6_ADDR[4:0]: begin
			s_next.pa6_out = hwdata_in[0];
			s_next.pa6_drive = hwdata_in[1];
		end
		default: begin
			s_next.armed = s_reg.armed;
		end
		endcase
	end
	// Start-up and sleep sequence
	case (s_reg.fsm)
	clk_mode_pkg::ST_START: begin
		if (is_ext(s_reg.mode)) begin
			s_next.fsm = clk_mode_pkg::ST_RUN;
		end else begin
			s_next.fsm = clk_mode_pkg::ST_WAIT;
			s_next.cnt = 16'(STARTUP_CYCLES - 1);
		end
	end
	clk_mode_pkg::ST_WAIT: begin
		if (s_reg.cnt == 16'h0) begin
			s_next.fsm = clk_mode_pkg::ST_RUN;
		end else begin
			s_next.cnt = s_reg.cnt - 16'h1;
		end
	end
	clk_mode_pkg::ST_RUN: begin
		if (s_reg.sleep_req) begin
			s_next.fsm = clk_mode_pkg::ST_SLEEP;
		end
	end
	clk_mode_pkg::ST_SLEEP: begin
		if (s_reg.sync2.wake) begin
			s_next.fsm = clk_mode_pkg::ST_START;
			s_next.sleep_req = 1'b0;
		end
	end
	default: begin
		s_next.fsm = clk_mode_pkg::ST_START;
	end
	endcase
	// A new mode restarts the sequence whatever state it was in
	if (s_reg.wr_pend && s_reg.armed &&
		s_reg.wr_idx == clk_mode_pkg::CLOCK_CONFIG_HIGH_ADDR[4:2] &&
		hwdata_in[3:0] <= clk_mode_pkg::INTERNAL_CORE_EXTCLK_USB_CLKOUT) begin
		s_next.fsm = clk_mode_pkg::ST_START;
	end
	// Core clock tick
	s_next.core_tick = 1'b0;
	if (s_reg.fsm == clk_mode_pkg::ST_RUN) begin
		case (eff_src)
		clk_mode_pkg::SRC_PRIMARY: begin
			s_next.core_tick = post_tick;
		end
		clk_mode_pkg::SRC_SECONDARY: begin
			s_next.core_tick = s_reg.sync2.secondary;
		end
		default: begin
			s_next.core_tick = s_reg.sync2.internal;
		end
		endcase
	end
	// USB tick always from the primary chain
	s_next.usb_tick = 1'b0;
	if (s_reg.usb_en && s_reg.fsm != clk_mode_pkg::ST_START &&
		s_reg.fsm != clk_mode_pkg::ST_WAIT) begin
		if (s_reg.usb_full) begin
			s_next.usb_tick = is_pll(s_reg.mode) ?
				s_reg.sync2.pll : prim_tick;
		end else begin
			s_next.usb_tick = ls_tick;
		end
	end
	// Second oscillator pin
	if (half_tick) begin
		s_next.clkout_lvl = ~s_reg.clkout_lvl;
	end
	if (is_clkout(s_reg.mode)) begin
		s_next.pin_oe_n = 1'b0;
		s_next.pin_out = s_reg.clkout_lvl;
	end else if (is_io(s_reg.mode)) begin
		s_next.pin_oe_n = ~s_reg.pa6_drive;
		s_next.pin_out = s_reg.pa6_out;
	end else begin
		s_next.pin_oe_n = 1'b1;
		s_next.pin_out = 1'b0;
	end
end

always_ff @(posedge core_clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		s_reg <= '0;
		s_reg.mode <= clk_mode_pkg::MODE_RESET;
		s_reg.postscale <= clk_mode_pkg::POSTSCALE_RESET;
		s_reg.ready <= 1'b1;
		s_reg.pin_oe_n <= 1'b1;
	end else begin
		s_reg <= s_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// Outputs
assign ahb_out.hrdata = s_reg.rdata;
assign ahb_out.hreadyout = s_reg.ready;
assign ahb_out.hresp = 1'b0;
assign core_tick_out = s_reg.core_tick;
assign usb_tick_out = s_reg.usb_tick;
assign osc_out_pin_out = s_reg.pin_out;
assign osc_out_pin_oe_n_out = s_reg.pin_oe_n;
assign core_running_out = (s_reg.fsm == clk_mode_pkg::ST_RUN);

////////////////////////////////////////////////////////////////////////////
// Checks
default clocking cb @(posedge core_clk_in);
endclocking
default disable iff (!nrst_in);

sequence seq_start_ext;
	s_reg.fsm == clk_mode_pkg::ST_START && is_ext(s_reg.mode);
endsequence

sequence seq_start_xtal;
	s_reg.fsm == clk_mode_pkg::ST_START && !is_ext(s_reg.mode);
endsequence

AST_EXT_NO_STARTUP: assert property (
	seq_start_ext |=> core_running_out)
	else $error("external clock mode delayed start-up");

AST_XTAL_STARTUP: assert property (
	seq_start_xtal |=> !core_running_out [*2])
	else $error("crystal mode skipped start-up delay");

AST_CLKOUT_DRIVEN: assert property (
	is_clkout(s_reg.mode) && $stable(s_reg.mode) |=> !osc_out_pin_oe_n_out)
	else $error("clock-out mode not driving second pin");

AST_CLKOUT_FOLLOWS: assert property (
	is_clkout(s_reg.mode) && $stable(s_reg.mode)
	|=> osc_out_pin_out == $past(s_reg.clkout_lvl))
	else $error("clock-out pin not following divided clock");

AST_IO_PIN: assert property (
	is_io(s_reg.mode) && $stable(s_reg.mode)
	|=> osc_out_pin_oe_n_out == !$past(s_reg.pa6_drive))
	else $error("I/O mode pin enable wrong");

AST_CFG_LOCKED: assert property (
	!s_reg.armed |=> $stable(s_reg.mode) && $stable(s_reg.postscale))
	else $error("configuration changed without unlock");

AST_INT_CORE: assert property (
	is_int(s_reg.mode) && s_reg.src == clk_mode_pkg::SRC_PRIMARY
	&& core_running_out && !s_reg.sync2.internal |=> !core_tick_out)
	else $error("internal mode core not on internal oscillator");

AST_USB_PRIMARY: assert property (
	s_reg.usb_en && s_reg.usb_full && !is_pll(s_reg.mode) && !prim_tick
	|=> !usb_tick_out)
	else $error("USB tick not from primary source");

AST_USB_OFF: assert property (
	!s_reg.usb_en |=> !usb_tick_out)
	else $error("USB tick while disabled");

AST_CORE_SLEEP: assert property (
	s_reg.fsm == clk_mode_pkg::ST_SLEEP |=> !core_tick_out)
	else $error("core ticking during sleep");

endmodule

// ==== tb/osc_partner.sv ====
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// External clock and oscillator ticks seen at the block's pins
module osc_partner (
	input wire logic clk_in,
	input wire logic wake_in,
	input wire logic ext_level_in,
	input wire logic pin_level_in,
	input wire logic pin_oe_n_in,
	output clk_mode_pkg::pins_type pins_out
);
	logic [3:0] cnt = 4'h0;
	always @(posedge clk_in) begin
		cnt <= cnt + 4'h1;
	end
	always_comb begin
		pins_out.wake = wake_in;
		pins_out.osc_in = cnt[2];
		pins_out.pll = cnt[0];
		pins_out.secondary = (cnt == 4'h5);
		pins_out.internal = (cnt[1:0] == 2'h3);
		// Undriven second pin follows the outside level
		pins_out.osc_out = pin_oe_n_in ? ext_level_in : pin_level_in;
	end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	localparam logic [7:0] A_LOW = clk_mode_pkg::CLOCK_CONFIG_LOW_ADDR;
	localparam logic [7:0] A_HIGH = clk_mode_pkg::CLOCK_CONFIG_HIGH_ADDR;
	localparam logic [7:0] A_CTRL = clk_mode_pkg::ACTIVE_CLOCK_CONTROL_ADDR;
	localparam logic [7:0] A_STAT = clk_mode_pkg::CLOCK_STATUS_ADDR;
	localparam logic [7:0] A_KEY = clk_mode_pkg::CONFIG_KEY_ADDR;
	localparam logic [7:0] A_PA6 = clk_mode_pkg::PORT_A_BIT6_ADDR;
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic hsel_in = 1'b0;
	logic [31:0] haddr_in = 32'h0;
	logic [1:0] htrans_in = 2'h0;
	logic hwrite_in = 1'b0;
	logic [2:0] hsize_in = 3'h2;
	logic [31:0] hwdata_in = 32'h0;
	logic wake = 1'b0;
	logic ext_level = 1'b0;
	clk_mode_pkg::pins_type pins;
	clk_mode_pkg::ahb_resp_type ahb;
	logic core_tick, usb_tick, pin_out, pin_oe_n, running;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_core, n_usb, n_pin;
	logic [31:0] rd;

	always #25 core_clk_in = ~core_clk_in;

	usb_mcu_clock_mode_select #(.STARTUP_CYCLES(40)) usb_mcu_clock_mode_select_i (
		.core_clk_in(core_clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
		.hsize_in(hsize_in), .hwdata_in(hwdata_in),
		.hready_in(ahb.hreadyout), .pins_in(pins), .ahb_out(ahb),
		.core_tick_out(core_tick), .usb_tick_out(usb_tick),
		.osc_out_pin_out(pin_out), .osc_out_pin_oe_n_out(pin_oe_n),
		.core_running_out(running)
	);
	osc_partner osc_partner_i (
		.clk_in(core_clk_in), .wake_in(wake), .ext_level_in(ext_level),
		.pin_level_in(pin_out), .pin_oe_n_in(pin_oe_n), .pins_out(pins)
	);

	////////////////////////////////////////////////////////////////////////
	// Checking and bus tasks
	task automatic finish_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_near(input int got, input int exp);
		samples_checked++;
		if (got > exp + 1 || got < exp - 1) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel_in <= 1'b1;
		haddr_in <= {24'h0, a};
		htrans_in <= 2'h2;
		hwrite_in <= wr;
		@(posedge core_clk_in);
		while (ahb.hreadyout !== 1'b1) @(posedge core_clk_in);
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		@(posedge core_clk_in);
		while (ahb.hreadyout !== 1'b1) @(posedge core_clk_in);
		rd = ahb.hrdata;
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check_eq(rd & m, e);
	endtask
	task automatic arm();
		bus(1'b1, A_KEY, {24'h0, clk_mode_pkg::CONFIG_KEY_VALUE});
	endtask
	task automatic set_mode(input logic [3:0] m);
		arm();
		bus(1'b1, A_HIGH, {28'h0, m});
	endtask
	task automatic set_low(input logic [31:0] v);
		arm();
		bus(1'b1, A_LOW, v);
	endtask
	task automatic measure(input int n);
		logic last_pin;
		repeat (8) @(posedge core_clk_in);
		n_core = 0;
		n_usb = 0;
		n_pin = 0;
		@(negedge core_clk_in);
		last_pin = pin_out;
		repeat (n) begin
			@(negedge core_clk_in);
			n_core += core_tick;
			n_usb += usb_tick;
			n_pin += (pin_out != last_pin);
			last_pin = pin_out;
		end
		@(posedge core_clk_in);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		check_eq({31'h0, ahb.hresp}, 32'h0);
		expect_reg(A_HIGH, 32'hffffffff,
			{28'h0, clk_mode_pkg::MODE_RESET});
		expect_reg(A_LOW, 32'hffffffff, 32'h0);
		bus(1'b1, 8'h40, 32'hffffffff);
		expect_reg(8'h40, 32'hffffffff, 32'h0);
	endtask
	task automatic t_lock();
		bus(1'b1, A_HIGH, 32'h4);
		expect_reg(A_HIGH, 32'hf, 32'h2);
		arm();
		bus(1'b1, A_HIGH, 32'hc);
		expect_reg(A_HIGH, 32'hf, 32'h2);
		bus(1'b1, A_HIGH, 32'h4);
		expect_reg(A_HIGH, 32'hf, 32'h4);
		bus(1'b1, A_HIGH, 32'h5);
		expect_reg(A_HIGH, 32'hf, 32'h4);
	endtask
	task automatic t_modes();
		logic [3:0] m;
		logic pll, ck;
		for (int i = 0; i < 12; i++) begin
			m = 4'(i);
			pll = (m == 4'h1) || (m == 4'h3) || (m == 4'h6) || (m == 4'h7);
			ck = (m == 4'h4) || (m == 4'h6) || (m == 4'hb);
			set_mode(m);
			expect_reg(A_HIGH, 32'hf, {28'h0, m});
			expect_reg(A_STAT, 32'hc, {28'h0, ck, pll, 2'h0});
			check_eq({31'h0, pin_oe_n}, {31'h0, ~ck});
		end
	endtask
	task automatic t_start();
		set_mode(4'h4);
		repeat (6) @(posedge core_clk_in);
		check_eq({31'h0, running}, 32'h1);
		set_mode(4'h0);
		repeat (6) @(posedge core_clk_in);
		check_eq({31'h0, running}, 32'h0);
		repeat (50) @(posedge core_clk_in);
		check_eq({31'h0, running}, 32'h1);
	endtask
	task automatic t_div();
		set_mode(4'h4);
		for (int d = 0; d < 4; d++) begin
			set_low(d);
			measure(400);
			check_near(n_core, 50 / (d + 1));
			check_near(n_pin, 25);
		end
	endtask
	task automatic t_usb();
		set_low(32'h0);
		bus(1'b1, A_CTRL, 32'ha);
		measure(400);
		check_near(n_core, 100);
		check_near(n_usb, 12);
		bus(1'b1, A_CTRL, 32'h9);
		measure(400);
		check_near(n_core, 25);
		check_near(n_usb, 12);
		set_low(32'h4);
		measure(400);
		check_near(n_usb, 50);
		set_mode(4'h3);
		repeat (50) @(posedge core_clk_in);
		bus(1'b1, A_CTRL, 32'h8);
		measure(400);
		check_near(n_usb, 200);
		bus(1'b1, A_CTRL, 32'h0);
	endtask
	task automatic t_io();
		set_mode(4'h5);
		bus(1'b1, A_PA6, 32'h3);
		repeat (3) @(posedge core_clk_in);
		check_eq({30'h0, pin_oe_n, pin_out}, 32'h1);
		bus(1'b1, A_PA6, 32'h0);
		ext_level <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		check_eq({31'h0, pin_oe_n}, 32'h1);
		expect_reg(A_PA6, 32'h4, 32'h4);
		ext_level <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		expect_reg(A_PA6, 32'h4, 32'h0);
		set_mode(4'ha);
		bus(1'b1, A_PA6, 32'h3);
		repeat (3) @(posedge core_clk_in);
		check_eq({30'h0, pin_oe_n, pin_out}, 32'h1);
		set_mode(4'hb);
		measure(400);
		check_near(n_pin, 25);
	endtask
	task automatic t_sleep();
		set_mode(4'h4);
		bus(1'b1, A_CTRL, 32'h4);
		measure(200);
		check_eq(n_core, 32'h0);
		expect_reg(A_STAT, 32'h2, 32'h2);
		wake <= 1'b1;
		repeat (10) @(posedge core_clk_in);
		wake <= 1'b0;
		measure(400);
		check_near(n_core, 50);
		expect_reg(A_CTRL, 32'h4, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (6) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_lock();
		t_modes();
		t_start();
		t_div();
		t_usb();
		t_io();
		t_sleep();
		finish_test();
	end
	initial begin
		#2000000;
		n_mismatch++;
		finish_test();
	end
endmodule
